// ### design/sensor_port_host.sv
// host microcontroller end of the serial host port
`timescale 1ns/1ps
`default_nettype none
`include "spi_link_defs.svh"

// Overview of operation
// - strap high or floating slave-only, low master-slave
// - slave-only: host always masters and clocks
// - data changes on fall, sampled on rise
// - host clock low around select edges, gaps
// - select held low until data-ready high again
// - sensor loads byte, then pulls data-ready low
// - host waits data-ready, sends null byte
// - sensor releases data-ready, waits for deselect
// - bad command: no data-ready, host times out
// - setup writes take roughly 10 to 300ms
// - reference lock takes roughly 800ms
// - status requests take up to 1ms
// - each command byte framed, 50us apart
// - no new byte until data-ready high
// - master-slave: one shared data line, master drives
// - host leads, then floats clock and data
// - sensor masters each reply byte, then slave
// - master raises select only after clock low
// - host takes reply bytes whenever they come
// - host waits 1ms after a whole exchange
// - sensor never transmits unprompted
// - every valid command gets one or more reply bytes
module sensor_port_host
   import spi_link_pkg::*;
#(
   parameter int HALF        = `SCK_HALF_CYC,
   parameter int GAP_CYC     = `CMD_GAP_CYC,
   parameter int GUARD_CYC   = `SEQ_GUARD_CYC,
   parameter int TIMEOUT_CYC = `REPLY_DELAY_CYC
) (
   // clock and reset
   input  wire logic       core_clk,
   input  wire logic       resetn,
   // link
   spi_link_if.host        lnk,
   // mode strap as seen by the host, high is slave-only
   input  wire logic       slave_only_mode,
   // command request
   input  wire logic       cmd_valid,
   input  wire logic [7:0] cmd_byte0,
   input  wire logic [7:0] cmd_byte1,
   input  wire logic       cmd_two,
   input  wire logic [3:0] reply_len,
   output logic            cmd_ready,
   // reply and outcome
   output logic            reply_valid,
   output logic [7:0]      reply_byte,
   output logic            timeout
);

   // ----------------------------------------
   // pin synchronisers
   // ----------------------------------------
   logic [5:0] pin_raw, pin_a, pin_b;
   // reset to idle levels: strap, data-ready and select high; data and clock low
   localparam logic [5:0] PIN_IDLE = 6'h38;
   assign pin_raw = {slave_only_mode, lnk.drdy_n, lnk.ss_n,
                     lnk.miso, lnk.mosi, lnk.sck};

   genvar g;
   generate
      for (g = 0; g < 6; g++) begin : g_sync
         always_ff @(posedge core_clk or negedge resetn) begin
            if (!resetn) begin
               pin_a[g] <= PIN_IDLE[g];
               pin_b[g] <= PIN_IDLE[g];
            end else begin
               pin_a[g] <= pin_raw[g];
               pin_b[g] <= pin_a[g];
            end
         end
      end
   endgenerate

   host_state_t st, next_st;
   logic [1:0]  idx, next_idx;
   logic [3:0]  cnt, next_cnt;
   logic [3:0]  len, next_len;
   logic        two, next_two;
   logic [7:0]  b1, next_b1;
   logic [31:0] timer, next_timer;
   logic        ss_out, next_ss_out;
   logic        oe_n, next_oe_n;
   logic        sck_d;
   logic        next_cmd_ready, next_reply_valid, next_timeout;
   logic [7:0]  next_reply_byte;
   logic        ms, drdy_hi, load, got_all;
   logic [7:0]  load_byte;
   logic        eng_sck, eng_dout, eng_done, eng_fin;
   logic [7:0]  eng_rx;

   assign ms      = !pin_b[5];
   assign drdy_hi = pin_b[4];
   assign got_all = ({1'h0, cnt} + 5'h01) >= {1'h0, len};

   // own clock when leading, sensor clock edges when listening
   spi_byte_engine #(.HALF(HALF)) u_eng (
      .core_clk  (core_clk),
      .resetn    (resetn),
      .gen       (1'h1),
      .load      (load),
      .load_byte (load_byte),
      .clr       (pin_b[3]),
      .ext_rise  (pin_b[0] && !sck_d),
      .ext_fall  (!pin_b[0] && sck_d),
      .din       (ms ? pin_b[1] : pin_b[2]),
      .sck       (eng_sck),
      .dout      (eng_dout),
      .rx_byte   (eng_rx),
      .done      (eng_done),
      .fin       (eng_fin)
   );

   // host drives all three lines whenever it is master
   assign lnk.host_sck_out   = eng_sck;
   assign lnk.host_mosi_out  = eng_dout;
   assign lnk.host_ss_out    = ss_out;
   assign lnk.host_sck_oe_n  = oe_n;
   assign lnk.host_mosi_oe_n = oe_n;
   assign lnk.host_ss_oe_n   = oe_n;

   // ----------------------------------------
   // exchange sequencing
   // ----------------------------------------
   always_comb begin
      next_st = st;
      next_idx = idx;
      next_cnt = cnt;
      next_len = len;
      next_two = two;
      next_b1 = b1;
      next_timer = timer + 32'h0000_0001;
      next_ss_out = ss_out;
      next_oe_n = oe_n;
      next_reply_valid = 1'h0;
      next_reply_byte = reply_byte;
      next_timeout = 1'h0;
      load = 1'h0;
      load_byte = cmd_byte0;
      unique case (st)
         H_IDLE: begin
            next_timer = 32'h0000_0000;
            // slave-only host stays master; master-slave host idles as slave
            next_oe_n = ms;
            if (cmd_valid && cmd_ready) begin
               load = 1'h1;                        // lead-in keeps clock low
               next_oe_n = 1'h0;
               next_ss_out = 1'h0;
               next_idx = 2'h0;
               next_b1 = cmd_byte1;
               next_two = cmd_two;
               next_len = reply_len;
               next_cnt = 4'h0;
               next_st = H_BYTE;
            end
         end
         H_BYTE: begin
            next_timer = 32'h0000_0000;
            if (eng_done && (idx == 2'h2)) begin
               next_reply_byte = eng_rx;
            end
            if (eng_fin) begin
               if (idx == 2'h2) begin
                  next_st = H_WAIT_HI;             // select stays low
               end else begin
                  next_ss_out = 1'h1;              // clock low by now
                  if ((idx == 2'h0) && two) begin
                     next_st = H_GAP;
                  end else if (ms) begin
                     next_oe_n = 1'h1;             // float and listen
                     next_st = H_LISTEN;
                  end else begin
                     next_st = H_WAIT_RDY;
                  end
               end
            end
         end
         H_GAP: begin
            if (timer == 32'(GAP_CYC - 1)) begin
               load = 1'h1;                        // second byte own frame
               load_byte = b1;
               next_ss_out = 1'h0;
               next_idx = 2'h1;
               next_st = H_BYTE;
            end
         end
         H_WAIT_RDY: begin
            if (!drdy_hi) begin
               load = 1'h1;                        // fetch with null byte
               load_byte = `NULL_BYTE;
               next_ss_out = 1'h0;
               next_idx = 2'h2;
               next_st = H_BYTE;
            end else if (timer == 32'(TIMEOUT_CYC - 1)) begin
               next_timeout = 1'h1;                // next reply byte never came
               next_timer = 32'h0000_0000;
               next_st = H_GUARD;
            end
         end
         H_WAIT_HI: begin
            next_timer = 32'h0000_0000;
            if (drdy_hi) begin
               next_ss_out = 1'h1;                 // only after release
               next_reply_valid = 1'h1;
               next_cnt = cnt + 4'h1;
               next_st = got_all ? H_GUARD : H_WAIT_RDY;
            end
         end
         H_LISTEN: begin
            if (eng_done) begin
               next_reply_valid = 1'h1;            // irregular spacing is fine
               next_reply_byte = eng_rx;
               next_cnt = cnt + 4'h1;
               next_timer = 32'h0000_0000;
               if (got_all) begin
                  next_st = H_GUARD;
               end
            end else if (timer == 32'(TIMEOUT_CYC - 1)) begin
               next_timeout = 1'h1;
               next_timer = 32'h0000_0000;
               next_st = H_GUARD;
            end
         end
         H_GUARD: begin
            next_oe_n = ms;
            if (timer == 32'(GUARD_CYC - 1)) begin
               next_st = H_IDLE;                   // quiet time after exchange
            end
         end
         default: begin
            next_st = H_IDLE;
         end
      endcase
      // slave-only host must also see data-ready released
      next_cmd_ready = (next_st == H_IDLE) && (ms || drdy_hi) &&
                       !(cmd_valid && cmd_ready);
   end

   // state registers
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         st <= H_IDLE;
         idx <= 2'h0;
         cnt <= 4'h0;
         len <= 4'h0;
         two <= 1'h0;
         b1 <= 8'h00;
         timer <= 32'h0000_0000;
         ss_out <= 1'h1;
         oe_n <= 1'h1;
         sck_d <= 1'h0;
         cmd_ready <= 1'h0;
         reply_valid <= 1'h0;
         reply_byte <= 8'h00;
         timeout <= 1'h0;
      end else begin
         st <= next_st;
         idx <= next_idx;
         cnt <= next_cnt;
         len <= next_len;
         two <= next_two;
         b1 <= next_b1;
         timer <= next_timer;
         ss_out <= next_ss_out;
         oe_n <= next_oe_n;
         sck_d <= pin_b[0];
         cmd_ready <= next_cmd_ready;
         reply_valid <= next_reply_valid;
         reply_byte <= next_reply_byte;
         timeout <= next_timeout;
      end
   end

endmodule // sensor_port_host

`default_nettype wire

// ### inc/spi_link_defs.svh
// timing and format constants for the touch sensor serial host port
`ifndef SPI_LINK_DEFS_SVH
`define SPI_LINK_DEFS_SVH

// core clock rate
`define CLK_MHZ         100
// fastest allowed serial clock
`define SCK_MAX_KHZ     1500
// half serial clock period in core cycles, rounded up
`define SCK_HALF_CYC    ((`CLK_MHZ*1000+2*`SCK_MAX_KHZ-1)/(2*`SCK_MAX_KHZ))
// least space between two command bytes
`define CMD_GAP_US      50
`define CMD_GAP_CYC     (`CMD_GAP_US*`CLK_MHZ)
// least quiet time after a whole exchange
`define SEQ_GUARD_US    1000
`define SEQ_GUARD_CYC   (`SEQ_GUARD_US*`CLK_MHZ)
// reply_delay_time: longest typical wait for a reply byte
`define REPLY_DELAY_MS  800
`define REPLY_DELAY_CYC (`REPLY_DELAY_MS*1000*`CLK_MHZ)
// byte clocked out by the host to fetch a reply byte
`define NULL_BYTE       8'h00

`endif

// ### inc/spi_link_pkg.sv
// state types of the serial host port ends
package spi_link_pkg;

   typedef enum logic [2:0] {
      D_IDLE   = 3'b000,
      D_LOADED = 3'b001,
      D_HOLD   = 3'b010,
      D_MASTER = 3'b011,
      D_MWAIT  = 3'b100
   } dev_state_t;

   typedef enum logic [2:0] {
      H_IDLE     = 3'b000,
      H_BYTE     = 3'b001,
      H_GAP      = 3'b010,
      H_WAIT_RDY = 3'b011,
      H_WAIT_HI  = 3'b100,
      H_LISTEN   = 3'b101,
      H_GUARD    = 3'b110
   } host_state_t;

endpackage

// ### inc/spi_link_if.sv
// shared serial link between the sensor port and its host
`timescale 1ns/1ps
`default_nettype none

interface spi_link_if;
   // strap pin, driven by the bench
   logic port_mode_select_pin;
   // resolved wires
   logic sck;
   logic mosi;
   logic miso;
   logic ss_n;
   logic drdy_n;
   // device drives
   logic dev_sck_out;
   logic dev_sck_oe_n;
   logic dev_mosi_out;
   logic dev_mosi_oe_n;
   logic dev_ss_out;
   logic dev_ss_oe_n;
   logic dev_miso;
   logic dev_drdy_n;
   // host drives
   logic host_sck_out;
   logic host_sck_oe_n;
   logic host_mosi_out;
   logic host_mosi_oe_n;
   logic host_ss_out;
   logic host_ss_oe_n;

   // undriven clock sits low, select pulled high
   assign sck  = !dev_sck_oe_n ? dev_sck_out :
                 (!host_sck_oe_n ? host_sck_out : 1'h0);
   assign mosi = !dev_mosi_oe_n ? dev_mosi_out :
                 (!host_mosi_oe_n ? host_mosi_out : 1'h0);
   assign ss_n = !dev_ss_oe_n ? dev_ss_out :
                 (!host_ss_oe_n ? host_ss_out : 1'h1);
   assign miso   = dev_miso;
   assign drdy_n = dev_drdy_n;

   modport dev (
      input  sck, mosi, ss_n, port_mode_select_pin,
      output dev_sck_out, dev_sck_oe_n, dev_mosi_out, dev_mosi_oe_n,
      output dev_ss_out, dev_ss_oe_n, dev_miso, dev_drdy_n
   );

   modport host (
      input  sck, mosi, miso, ss_n, drdy_n,
      output host_sck_out, host_sck_oe_n, host_mosi_out, host_mosi_oe_n,
      output host_ss_out, host_ss_oe_n
   );

endinterface

`default_nettype wire

// ### design/spi_byte_engine.sv
// byte shifter with its own clock maker or outside clock edges
`timescale 1ns/1ps
`default_nettype none
`include "spi_link_defs.svh"

module spi_byte_engine
   import spi_link_pkg::*;
#(
   parameter int HALF = `SCK_HALF_CYC
) (
   // clock and reset
   input  wire logic       core_clk,
   input  wire logic       resetn,
   // control
   input  wire logic       gen,
   input  wire logic       load,
   input  wire logic [7:0] load_byte,
   input  wire logic       clr,
   // outside edges and data
   input  wire logic       ext_rise,
   input  wire logic       ext_fall,
   input  wire logic       din,
   // results
   output logic            sck,
   output logic            dout,
   output logic [7:0]      rx_byte,
   output logic            done,
   output logic            fin
);

   logic [7:0]  tx, next_tx;
   logic [6:0]  rx, next_rx;
   logic [2:0]  bits, next_bits;
   logic        act, next_act;
   logic [4:0]  ph, next_ph;
   logic [15:0] hcnt, next_hcnt;
   logic        next_sck, next_done, next_fin;
   logic [7:0]  next_rx_byte;
   logic        hit, rise_e, fall_e;

   assign dout = tx[7];

   // ----------------------------------------
   // phase walk: lead-in low, 8 pulses, tail low
   // ----------------------------------------
   always_comb begin
      hit    = act && (hcnt == 16'(HALF - 1));
      rise_e = act ? (hit && !ph[0] && (ph != 5'h10)) : ext_rise;
      fall_e = act ? (hit && ph[0]) : ext_fall;
      next_tx = tx;
      next_rx = rx;
      next_bits = bits;
      next_act = act;
      next_ph = ph;
      next_hcnt = hcnt;
      next_sck = sck;
      next_rx_byte = rx_byte;
      next_done = 1'h0;
      next_fin = 1'h0;
      if (load) begin
         next_tx = load_byte;
         next_bits = 3'h0;
         next_act = gen;
         next_ph = 5'h00;
         next_hcnt = 16'h0000;
         next_sck = 1'h0;
      end else begin
         if (act) begin
            next_hcnt = hit ? 16'h0000 : hcnt + 16'h0001;
            if (hit) begin
               next_ph = ph + 5'h01;
               next_sck = rise_e;                  // clock idles low
            end
            if (hit && (ph == 5'h10)) begin
               next_act = 1'h0;                    // tail half already low
               next_fin = 1'h1;
            end
         end else if (clr) begin
            next_bits = 3'h0;                      // deselect realigns framing
         end
         if (rise_e) begin
            next_rx = {rx[5:0], din};              // sample on rising edge
            next_bits = bits + 3'h1;
            if (bits == 3'h7) begin
               next_done = 1'h1;                   // eight bits, msb first
               next_rx_byte = {rx, din};
            end
         end
         if (fall_e) begin
            next_tx = {tx[6:0], 1'h0};             // change on falling edge
         end
      end
   end

   // state registers
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         tx <= 8'h00;
         rx <= 7'h00;
         bits <= 3'h0;
         act <= 1'h0;
         ph <= 5'h00;
         hcnt <= 16'h0000;
         sck <= 1'h0;
         rx_byte <= 8'h00;
         done <= 1'h0;
         fin <= 1'h0;
      end else begin
         tx <= next_tx;
         rx <= next_rx;
         bits <= next_bits;
         act <= next_act;
         ph <= next_ph;
         hcnt <= next_hcnt;
         sck <= next_sck;
         rx_byte <= next_rx_byte;
         done <= next_done;
         fin <= next_fin;
      end
   end

endmodule // spi_byte_engine

`default_nettype wire

// ### design/sensor_port_dev.sv
// sensor end of the serial host port
`timescale 1ns/1ps
`default_nettype none
`include "spi_link_defs.svh"

module sensor_port_dev
   import spi_link_pkg::*;
#(
   parameter int HALF = `SCK_HALF_CYC
) (
   // clock and reset
   input  wire logic       core_clk,
   input  wire logic       resetn,
   // link
   spi_link_if.dev         lnk,
   // received command bytes
   output logic            cmd_valid,
   output logic [7:0]      cmd_byte,
   // reply bytes from the sensing core
   input  wire logic       reply_valid,
   input  wire logic [7:0] reply_byte,
   input  wire logic       reply_last,
   output logic            reply_ready
);

   // ----------------------------------------
   // pin synchronisers
   // ----------------------------------------
   logic [3:0] pin_raw, pin_a, pin_b;
   // reset to idle levels (strap high, select high, data and clock low): no false edge
   localparam logic [3:0] PIN_IDLE = 4'hC;
   assign pin_raw = {lnk.port_mode_select_pin, lnk.ss_n, lnk.mosi, lnk.sck};

   genvar g;
   generate
      for (g = 0; g < 4; g++) begin : g_sync
         always_ff @(posedge core_clk or negedge resetn) begin
            if (!resetn) begin
               pin_a[g] <= PIN_IDLE[g];
               pin_b[g] <= PIN_IDLE[g];
            end else begin
               pin_a[g] <= pin_raw[g];
               pin_b[g] <= pin_a[g];
            end
         end
      end
   endgenerate

   dev_state_t st, next_st;
   logic       drdy_n, next_drdy_n;
   logic       ss_out, next_ss_out;
   logic       oe_n, next_oe_n;
   logic       pending, next_pending;
   logic       last, next_last;
   logic       sck_d;
   logic       next_cmd_valid, next_reply_ready;
   logic [7:0] next_cmd_byte;
   logic       mode_ms, take, load;
   logic       eng_sck, eng_dout, eng_done, eng_fin;
   logic [7:0] eng_rx;

   // floating or high strap means slave-only, low means master-slave
   assign mode_ms = !pin_b[3];
   assign take = reply_valid && reply_ready;

   spi_byte_engine #(.HALF(HALF)) u_eng (
      .core_clk  (core_clk),
      .resetn    (resetn),
      .gen       (mode_ms),
      .load      (load),
      .load_byte (reply_byte),
      .clr       (pin_b[2]),
      .ext_rise  (pin_b[0] && !sck_d),
      .ext_fall  (!pin_b[0] && sck_d),
      .din       (pin_b[1]),
      .sck       (eng_sck),
      .dout      (eng_dout),
      .rx_byte   (eng_rx),
      .done      (eng_done),
      .fin       (eng_fin)
   );

   // master drives clock, data and select together
   assign lnk.dev_sck_out   = eng_sck;
   assign lnk.dev_mosi_out  = eng_dout;
   assign lnk.dev_miso      = eng_dout;
   assign lnk.dev_ss_out    = ss_out;
   assign lnk.dev_sck_oe_n  = oe_n;
   assign lnk.dev_mosi_oe_n = oe_n;
   assign lnk.dev_ss_oe_n   = oe_n;
   assign lnk.dev_drdy_n    = drdy_n;

   // ----------------------------------------
   // reply sequencing
   // ----------------------------------------
   always_comb begin
      next_st = st;
      next_drdy_n = drdy_n;
      next_ss_out = ss_out;
      next_oe_n = oe_n;
      next_pending = pending;
      next_last = last;
      next_cmd_valid = 1'h0;
      next_cmd_byte = cmd_byte;
      load = 1'h0;
      unique case (st)
         D_IDLE: begin
            if (eng_done) begin
               next_cmd_valid = 1'h1;
               next_cmd_byte = eng_rx;
               next_pending = 1'h1;                // a reply is now owed
            end
            if (take) begin
               load = 1'h1;
               next_last = reply_last;
               if (mode_ms) begin
                  next_oe_n = 1'h0;                // take over as master
                  next_ss_out = 1'h0;
                  next_st = D_MASTER;
               end else begin
                  next_drdy_n = 1'h0;              // byte loaded, then flag
                  next_st = D_LOADED;
               end
            end
         end
         D_LOADED: begin
            if (eng_done) begin
               next_drdy_n = 1'h1;                 // byte gone, release
               next_st = D_HOLD;
            end
         end
         D_HOLD: begin
            if (pin_b[2]) begin                    // wait for deselect
               if (last) begin
                  next_pending = 1'h0;
               end
               next_st = D_IDLE;
            end
         end
         D_MASTER: begin
            if (eng_fin) begin
               next_ss_out = 1'h1;                 // clock already low
               if (last) begin
                  next_oe_n = 1'h1;                // back to slave
                  next_pending = 1'h0;
                  next_st = D_IDLE;
               end else begin
                  next_st = D_MWAIT;
               end
            end
         end
         D_MWAIT: begin
            if (take) begin
               load = 1'h1;
               next_last = reply_last;
               next_ss_out = 1'h0;                 // one frame per byte
               next_st = D_MASTER;
            end
         end
      endcase
      // replies only against an owed command, never on its own; select must be seen
      // high, so a reply never lands in a live frame, though the host still holds the lines in the gap between two command bytes
      next_reply_ready = next_pending && pin_b[2] &&
                         ((next_st == D_IDLE) || (next_st == D_MWAIT));
   end

   // state registers
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         st <= D_IDLE;
         drdy_n <= 1'h1;
         ss_out <= 1'h1;
         oe_n <= 1'h1;
         pending <= 1'h0;
         last <= 1'h0;
         sck_d <= 1'h0;
         cmd_valid <= 1'h0;
         cmd_byte <= 8'h00;
         reply_ready <= 1'h0;
      end else begin
         st <= next_st;
         drdy_n <= next_drdy_n;
         ss_out <= next_ss_out;
         oe_n <= next_oe_n;
         pending <= next_pending;
         last <= next_last;
         sck_d <= pin_b[0];
         cmd_valid <= next_cmd_valid;
         cmd_byte <= next_cmd_byte;
         reply_ready <= next_reply_ready;
      end
   end

endmodule // sensor_port_dev

`default_nettype wire

// ### verification/link_monitor.sv
// assertion checker watching the shared serial link
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// link checker
// ----------------------------------------
module link_monitor (
   // clock and reset
   input wire logic core_clk,
   input wire logic resetn,
   // link wires
   input wire logic port_mode_select_pin,
   input wire logic sck,
   input wire logic mosi,
   input wire logic ss_n,
   input wire logic drdy_n,
   input wire logic dev_sck_oe_n,
   input wire logic host_sck_oe_n
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!resetn);
   // two drivers on one clock would short the wire
   no_contend_a: assert property (dev_sck_oe_n || host_sck_oe_n)
      else $error("clock driven by both ends");
   sel_clk_low_a: assert property ($changed(ss_n) |-> !sck && !$past(sck))
      else $error("select moved with clock high");
   clk_idle_a: assert property (ss_n |-> !sck)
      else $error("clock high outside a frame");
   data_on_fall_a: assert property (!ss_n && $changed(mosi) |-> !sck)
      else $error("data moved while clock high");
   ready_deselect_a: assert property ($fell(drdy_n) |-> ss_n)
      else $error("data ready signalled inside a frame");
   sel_after_ready_a: assert property (port_mode_select_pin && $rose(ss_n) |-> drdy_n)
      else $error("deselect before data ready released");
   dev_quiet_a: assert property (port_mode_select_pin |-> dev_sck_oe_n)
      else $error("sensor drove clock in slave-only mode");
   dev_take_sel_a: assert property ($fell(dev_sck_oe_n) |-> !ss_n)
      else $error("sensor took lines without select");
   // main scenarios
   ready_seen_c: cover property ($fell(drdy_n));
   dev_master_c: cover property ($fell(dev_sck_oe_n));
   frame_end_c: cover property ($rose(ss_n));
endmodule // link_monitor
`default_nettype wire

// ### verification/testbench.sv
// self-checking bench joining the sensor and host ends
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// bench top
// ----------------------------------------
module testbench;
   import spi_link_pkg::*;
   localparam int H = 8; // reply bit must cross both synchronisers within a half period
   logic       core_clk = 0, resetn = 0, mode = 1;
   logic       h_valid = 0, h_two = 0, h_ready, h_rvalid, h_tmo, d_cvalid, d_rready;
   logic [7:0] h_b0 = 0, h_b1 = 0, h_rbyte, d_cbyte, r_byte = 0, wire_byte = 0;
   logic [3:0] h_len = 1;
   logic       r_valid = 0, r_last = 0, sck_d = 0, tmo_seen = 0;
   logic [7:0] rq[$], got[$], hq[$];
   int         need = 1, miscompares = 0, compares = 0;
   spi_link_if lnk();
   assign lnk.port_mode_select_pin = mode;
   sensor_port_dev #(.HALF(H)) sensor_port_dev_i (.core_clk(core_clk), .resetn(resetn), .lnk(lnk.dev),
      .cmd_valid(d_cvalid), .cmd_byte(d_cbyte), .reply_valid(r_valid), .reply_byte(r_byte),
      .reply_last(r_last), .reply_ready(d_rready));
   sensor_port_host #(.HALF(H), .GAP_CYC(50), .GUARD_CYC(100), .TIMEOUT_CYC(2000)) sensor_port_host_i (
      .core_clk(core_clk), .resetn(resetn), .lnk(lnk.host), .slave_only_mode(mode), .cmd_valid(h_valid),
      .cmd_byte0(h_b0), .cmd_byte1(h_b1), .cmd_two(h_two), .reply_len(h_len), .cmd_ready(h_ready),
      .reply_valid(h_rvalid), .reply_byte(h_rbyte), .timeout(h_tmo));
   link_monitor link_monitor_i (.core_clk(core_clk), .resetn(resetn), .port_mode_select_pin(lnk.port_mode_select_pin),
      .sck(lnk.sck), .mosi(lnk.mosi), .ss_n(lnk.ss_n), .drdy_n(lnk.drdy_n), .dev_sck_oe_n(lnk.dev_sck_oe_n),
      .host_sck_oe_n(lnk.host_sck_oe_n));
   initial forever #5 core_clk = ~core_clk;
   // sensing core stand-in; replies held back until the whole command is in
   always @(posedge core_clk) begin
      sck_d <= lnk.sck;
      if (!lnk.ss_n && lnk.sck && !sck_d) wire_byte <= {wire_byte[6:0], lnk.mosi};
      if (d_cvalid) got.push_back(d_cbyte);
      if (h_rvalid) hq.push_back(h_rbyte);
      if (h_tmo) tmo_seen <= 1;
      if (r_valid && d_rready) r_valid <= 0;
      else if (!r_valid && rq.size() > 0 && got.size() >= need) begin
         r_valid <= 1;
         r_byte  <= rq[0];
         r_last  <= (rq.size() == 1);
         void'(rq.pop_front());
      end
   end
   task automatic check(string n, logic [7:0] s, logic [7:0] e);
      compares++;
      if (s !== e) begin
         miscompares++;
         $display("wrong value %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic final_report;
      if (miscompares == 0 && compares > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   // one whole exchange; waits are bounded so a hang shows as a mismatch
   task automatic xfer(logic [7:0] b0, logic [7:0] b1, logic two, int n);
      int i;
      got.delete();
      hq.delete();
      need = two ? 2 : 1;
      for (i = 0; i < 500 && h_ready !== 1'h1; i++) @(posedge core_clk);
      tmo_seen <= 0;
      h_valid <= 1; h_b0 <= b0; h_b1 <= b1; h_two <= two; h_len <= 4'(n);
      @(posedge core_clk);
      h_valid <= 0;
      for (i = 0; i < 4000 && hq.size() < n && tmo_seen !== 1'h1; i++) @(posedge core_clk);
   endtask
   initial begin
      repeat (20000) @(posedge core_clk);
      miscompares++;
      final_report();
   end
   initial begin
      for (int m = 1; m >= 0; m--) begin
         resetn <= 0;
         mode   <= m[0];
         repeat (8) @(posedge core_clk);
         resetn <= 1;
         repeat (4) @(posedge core_clk);
         rq = '{8'h67};
         xfer(8'h67, 8'h00, 0, 1);
         check("cmd byte", got[0], 8'h67);
         check("echo", hq[0], 8'h67);
         check("ready line", {7'h0, lnk.drdy_n}, 8'h01);
         check("wire byte", wire_byte, m ? 8'h00 : 8'h67);
         rq = '{8'h5A, 8'hC3};
         xfer(8'hA5, 8'h3C, 1, 2);
         check("first cmd", got[0], 8'hA5);
         check("second cmd", got[1], 8'h3C);
         check("reply 0", hq[0], 8'h5A);
         check("reply 1", hq[1], 8'hC3);
         check("last wire byte", wire_byte, m ? 8'h00 : 8'hC3);
         rq.delete();
         xfer(8'h81, 8'h00, 0, 1);
         check("timeout", {7'h0, tmo_seen}, 8'h01);
         check("no reply", 8'(hq.size()), 8'h00);
      end
      final_report();
   end
endmodule // testbench
`default_nettype wire
